/* File: core/dltd_pkg.sv */
package dltd_pkg;

    // Clocking and loop timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned LOOP_MS         = 20;
    localparam int unsigned LOOP_CYCLES     = CLK_HZ / 1000 * LOOP_MS;
    localparam int unsigned LOOPS_PER_S     = 1000 / LOOP_MS;
    localparam int unsigned S_PER_MIN       = 60;
    localparam int unsigned LOOPS_PER_MIN   = S_PER_MIN * LOOPS_PER_S;
    localparam int unsigned PWM_HZ          = 10_000;
    localparam int unsigned PWM_STEPS       = 100;
    localparam int unsigned PWM_TICK_CYCLES = CLK_HZ / (PWM_HZ * PWM_STEPS);
    localparam logic [6:0]  DUTY_FULL       = 7'h64;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STEP    = 8'h04;
    localparam logic [7:0] ADDR_LEVEL   = 8'h08;
    localparam logic [7:0] ADDR_WAIT    = 8'h0C;
    localparam logic [7:0] ADDR_LO_LIM  = 8'h10;
    localparam logic [7:0] ADDR_HI_LIM  = 8'h14;
    localparam logic [7:0] ADDR_OC_LIM  = 8'h18;
    localparam logic [7:0] ADDR_KEYOFF  = 8'h1C;
    localparam logic [7:0] ADDR_STATUS  = 8'h20;
    localparam logic [7:0] ADDR_MASK    = 8'h24;
    localparam logic [7:0] ADDR_STATE   = 8'h28;

    // Status and mask bit positions
    localparam int unsigned ST_LO      = 0;
    localparam int unsigned ST_HI      = 1;
    localparam int unsigned ST_KEYOFF  = 2;
    localparam int unsigned ST_DIMDONE = 3;

    // Reset values
    localparam logic        RST_DIM_EN = 1'b1;
    localparam logic [3:0]  RST_STEP   = 4'h1;
    localparam logic [6:0]  RST_LEVEL  = 7'h50;
    localparam logic [12:0] RST_WAIT   = 13'h0014;
    localparam logic [6:0]  RST_LO_LIM = 7'h00;
    localparam logic [6:0]  RST_HI_LIM = 7'h64;
    localparam logic [6:0]  RST_OC_LIM = 7'h00;
    localparam logic [6:0]  RST_KEYOFF = 7'h0A;
    localparam logic [3:0]  RST_MASK   = 4'h0;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PH_OFF,
        PH_FULL,
        PH_KEYOUT,
        PH_WAIT,
        PH_DIM
    } dltd_phase_t;

    typedef struct packed {
        logic        dim_en;
        logic [3:0]  step;
        logic [6:0]  level;
        logic [12:0] wait_s;
        logic [6:0]  lo_lim;
        logic [6:0]  hi_lim;
        logic [6:0]  oc_lim;
        logic [6:0]  keyoff;
    } dltd_cfg_t;

    localparam dltd_cfg_t RST_CFG = '{RST_DIM_EN, RST_STEP, RST_LEVEL,
        RST_WAIT, RST_LO_LIM, RST_HI_LIM, RST_OC_LIM, RST_KEYOFF};

    typedef struct packed {
        logic        door;
        logic        ignition;
    } dltd_sw_t;

endpackage

/* File: core/dltd_tick.sv */
`timescale 1ns/1ps
module dltd_tick #(
    parameter int unsigned DIV = 2
) (
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    output logic      tick_out
);
    typedef struct packed {
        logic [19:0] cnt;
        logic        tick;
    } dltd_tick_st_t;

    dltd_tick_st_t st_r;
    dltd_tick_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == 20'(DIV - 1))
        begin
            st_nxt.cnt = 20'h00000;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = 20'(st_r.cnt + 20'h00001);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick_out = st_r.tick;
endmodule

/* File: core/dltd_pwm.sv */
`timescale 1ns/1ps
module dltd_pwm (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    input  wire logic       tick_in,
    input  wire logic [6:0] duty_in,
    output logic            pwm_out
);
    typedef struct packed {
        logic [6:0] cnt;
        logic       pwm;
    } dltd_pwm_st_t;

    dltd_pwm_st_t st_r;
    dltd_pwm_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (tick_in)
        begin
            if (st_r.cnt == 7'(dltd_pkg::PWM_STEPS - 1))
                st_nxt.cnt = 7'h00;
            else
                st_nxt.cnt = 7'(st_r.cnt + 7'h01);
            st_nxt.pwm = (st_nxt.cnt < duty_in);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pwm_out = st_r.pwm;
endmodule

/* File: core/dltd_dimmer.sv */
`timescale 1ns/1ps
module dltd_dimmer #(
    parameter int unsigned LOOP_CYCLES = dltd_pkg::LOOP_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        door_open_in,
    input  wire logic        ignition_in,
    input  wire logic [6:0]  lamp_current_in,
    output logic             lamp_pwm_out,
    output logic             irq_out
);
    typedef struct packed {
        dltd_pkg::dltd_sw_t    sw_meta;
        dltd_pkg::dltd_sw_t    sw;
        dltd_pkg::dltd_cfg_t   cfg;
        dltd_pkg::dltd_phase_t phase;
        logic [6:0]            duty;
        logic [11:0]           sub;
        logic [12:0]           units;
        logic [3:0]            status;
        logic [3:0]            mask;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
    } dltd_st_t;

    dltd_st_t   st_r;
    dltd_st_t   st_nxt;
    logic       loop_tick;
    logic       pwm_tick;
    logic       wr_go;
    logic       rd_go;
    logic       shut;
    logic [6:0] duty_o;
    logic       driving;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        return res;
    endfunction

    dltd_tick #(.DIV(LOOP_CYCLES)) u_loop (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .tick_out   (loop_tick)
    );

    dltd_tick #(.DIV(dltd_pkg::PWM_TICK_CYCLES)) u_pwm_tick (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .tick_out   (pwm_tick)
    );

    dltd_pwm u_pwm (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .tick_in    (pwm_tick),
        .duty_in    (duty_o),
        .pwm_out    (lamp_pwm_out)
    );

    assign shut = st_r.status[dltd_pkg::ST_HI];
    assign duty_o = shut ? 7'h00 : st_r.duty;
    assign driving = (duty_o != 7'h00);
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
    assign rd_go = s_axi_arvalid && !st_r.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;
    assign irq_out = |(st_r.status & st_r.mask);

    always_comb
    begin
        logic [31:0] wv;
        logic [3:0]  ev;
        logic [3:0]  clr;
        logic        sec_end;
        logic        min_end;
        st_nxt = st_r;
        wv = 32'h00000000;
        ev = 4'h0;
        clr = 4'h0;
        sec_end = (st_r.sub == 12'(dltd_pkg::LOOPS_PER_S - 1));
        min_end = (st_r.sub == 12'(dltd_pkg::LOOPS_PER_MIN - 1));
        st_nxt.sw_meta = '{door_open_in, ignition_in};
        st_nxt.sw = st_r.sw_meta;

        // Register writes
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        if (wr_go)
        begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = dltd_pkg::RESP_OKAY;
            unique case (s_axi_awaddr)
                dltd_pkg::ADDR_CTRL:
                begin
                    wv = merge({31'h0, st_r.cfg.dim_en}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.dim_en = wv[0];
                end
                dltd_pkg::ADDR_STEP:
                begin
                    wv = merge({28'h0, st_r.cfg.step}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.step = wv[3:0];
                end
                dltd_pkg::ADDR_LEVEL:
                begin
                    wv = merge({25'h0, st_r.cfg.level}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.level = wv[6:0];
                end
                dltd_pkg::ADDR_WAIT:
                begin
                    wv = merge({19'h0, st_r.cfg.wait_s}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.wait_s = wv[12:0];
                end
                dltd_pkg::ADDR_LO_LIM:
                begin
                    wv = merge({25'h0, st_r.cfg.lo_lim}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.lo_lim = wv[6:0];
                end
                dltd_pkg::ADDR_HI_LIM:
                begin
                    wv = merge({25'h0, st_r.cfg.hi_lim}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.hi_lim = wv[6:0];
                end
                dltd_pkg::ADDR_OC_LIM:
                begin
                    wv = merge({25'h0, st_r.cfg.oc_lim}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.oc_lim = wv[6:0];
                end
                dltd_pkg::ADDR_KEYOFF:
                begin
                    wv = merge({25'h0, st_r.cfg.keyoff}, s_axi_wdata,
                        s_axi_wstrb);
                    st_nxt.cfg.keyoff = wv[6:0];
                end
                dltd_pkg::ADDR_STATUS:
                    clr = s_axi_wstrb[0] ? s_axi_wdata[3:0] : 4'h0;
                dltd_pkg::ADDR_MASK:
                    if (s_axi_wstrb[0])
                        st_nxt.mask = s_axi_wdata[3:0];
                dltd_pkg::ADDR_STATE:
                    st_nxt.bresp = dltd_pkg::RESP_OKAY;
                default:
                    st_nxt.bresp = dltd_pkg::RESP_SLVERR;
            endcase
        end

        // Register reads
        if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
        if (rd_go)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = dltd_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dltd_pkg::ADDR_CTRL:   st_nxt.rdata = {31'h0, st_r.cfg.dim_en};
                dltd_pkg::ADDR_STEP:   st_nxt.rdata = {28'h0, st_r.cfg.step};
                dltd_pkg::ADDR_LEVEL:  st_nxt.rdata = {25'h0, st_r.cfg.level};
                dltd_pkg::ADDR_WAIT:   st_nxt.rdata = {19'h0, st_r.cfg.wait_s};
                dltd_pkg::ADDR_LO_LIM: st_nxt.rdata = {25'h0, st_r.cfg.lo_lim};
                dltd_pkg::ADDR_HI_LIM: st_nxt.rdata = {25'h0, st_r.cfg.hi_lim};
                dltd_pkg::ADDR_OC_LIM: st_nxt.rdata = {25'h0, st_r.cfg.oc_lim};
                dltd_pkg::ADDR_KEYOFF: st_nxt.rdata = {25'h0, st_r.cfg.keyoff};
                dltd_pkg::ADDR_STATUS: st_nxt.rdata = {28'h0, st_r.status};
                dltd_pkg::ADDR_MASK:   st_nxt.rdata = {28'h0, st_r.mask};
                dltd_pkg::ADDR_STATE:
                    st_nxt.rdata = {19'h0, st_r.sw.ignition, st_r.sw.door,
                        shut, st_r.phase, duty_o};
                default:
                begin
                    st_nxt.rdata = 32'h00000000;
                    st_nxt.rresp = dltd_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Lamp sequence
        unique case (st_r.phase)
            dltd_pkg::PH_OFF, dltd_pkg::PH_WAIT, dltd_pkg::PH_DIM:
            begin
                if (st_r.sw.door)
                begin
                    st_nxt.phase = dltd_pkg::PH_FULL;
                    st_nxt.duty = dltd_pkg::DUTY_FULL;
                    st_nxt.sub = 12'h000;
                    st_nxt.units = 13'h0000;
                end
                else if (st_r.phase == dltd_pkg::PH_WAIT && loop_tick)
                begin
                    st_nxt.sub = sec_end ? 12'h000 : 12'(st_r.sub + 12'h001);
                    if (sec_end)
                    begin
                        st_nxt.units = 13'(st_r.units + 13'h0001);
                        if (13'(st_r.units + 13'h0001) >= st_r.cfg.wait_s)
                            st_nxt.phase = dltd_pkg::PH_DIM;
                    end
                end
                else if (st_r.phase == dltd_pkg::PH_DIM && loop_tick)
                begin
                    if (st_r.duty <= {3'h0, st_r.cfg.step})
                    begin
                        st_nxt.duty = 7'h00;
                        st_nxt.phase = dltd_pkg::PH_OFF;
                        ev[dltd_pkg::ST_DIMDONE] = 1'b1;
                    end
                    else
                    begin
                        st_nxt.duty = 7'(st_r.duty - {3'h0, st_r.cfg.step});
                    end
                end
            end
            dltd_pkg::PH_FULL, dltd_pkg::PH_KEYOUT:
            begin
                if (!st_r.sw.door)
                begin
                    st_nxt.sub = 12'h000;
                    st_nxt.units = 13'h0000;
                    if (st_r.cfg.dim_en)
                    begin
                        st_nxt.phase = dltd_pkg::PH_WAIT;
                        st_nxt.duty = st_r.cfg.level;
                    end
                    else
                    begin
                        st_nxt.phase = dltd_pkg::PH_OFF;
                        st_nxt.duty = 7'h00;
                    end
                end
                else if (st_r.sw.ignition)
                begin
                    st_nxt.phase = dltd_pkg::PH_FULL;
                    st_nxt.duty = dltd_pkg::DUTY_FULL;
                    st_nxt.sub = 12'h000;
                    st_nxt.units = 13'h0000;
                end
                else if (st_r.phase == dltd_pkg::PH_FULL && loop_tick)
                begin
                    st_nxt.sub = min_end ? 12'h000 : 12'(st_r.sub + 12'h001);
                    if (min_end)
                    begin
                        st_nxt.units = 13'(st_r.units + 13'h0001);
                        if (13'(st_r.units + 13'h0001) >=
                            {6'h00, st_r.cfg.keyoff})
                        begin
                            st_nxt.phase = dltd_pkg::PH_KEYOUT;
                            st_nxt.duty = 7'h00;
                            ev[dltd_pkg::ST_KEYOFF] = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Current monitor, sampled each loop while driving
        if (loop_tick && driving)
        begin
            if (lamp_current_in < st_r.cfg.lo_lim)
                ev[dltd_pkg::ST_LO] = 1'b1;
            if (lamp_current_in > st_r.cfg.hi_lim)
                ev[dltd_pkg::ST_HI] = 1'b1;
        end
        st_nxt.status = (st_r.status & ~clr) | ev;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            st_r <= '0;
            st_r.cfg <= dltd_pkg::RST_CFG;
            st_r.mask <= dltd_pkg::RST_MASK;
            st_r.phase <= dltd_pkg::PH_OFF;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    a_door_full: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(st_r.sw.door) |=> st_r.phase == dltd_pkg::PH_FULL)
        else $error("door open did not give full output");

    a_nodim_off: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $fell(st_r.sw.door) && !st_r.cfg.dim_en |=> duty_o == 7'h00)
        else $error("lamp not off at close with dimming disabled");

    a_dim_step: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        loop_tick && !st_r.sw.door && st_r.phase == dltd_pkg::PH_DIM
        && st_r.duty > {3'h0, st_r.cfg.step}
        |=> st_r.duty == $past(st_r.duty) - {3'h0, $past(st_r.cfg.step)})
        else $error("dim step wrong");

    a_wait_level: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        st_r.phase == dltd_pkg::PH_WAIT |-> st_r.duty == st_r.cfg.level)
        else $error("wait level wrong");

    a_wait_expire: assert property (@(posedge clk_sys_in)
        disable iff (!rst_b_in)
        loop_tick && !st_r.sw.door && st_r.phase == dltd_pkg::PH_WAIT
        && st_r.sub == 12'(dltd_pkg::LOOPS_PER_S - 1)
        && 13'(st_r.units + 13'h0001) >= st_r.cfg.wait_s
        |=> st_r.phase == dltd_pkg::PH_DIM)
        else $error("wait expiry missed");

    a_low_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        loop_tick && driving && lamp_current_in < st_r.cfg.lo_lim
        |=> st_r.status[dltd_pkg::ST_LO])
        else $error("low current not flagged");

    a_high_off: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        loop_tick && driving && lamp_current_in > st_r.cfg.hi_lim
        |=> st_r.status[dltd_pkg::ST_HI] && duty_o == 7'h00)
        else $error("overcurrent not shut off");

    a_keyoff_out: assert property (@(posedge clk_sys_in)
        disable iff (!rst_b_in)
        st_r.phase == dltd_pkg::PH_KEYOUT |-> duty_o == 7'h00)
        else $error("key-off lamp still lit");

    a_dim_end: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        loop_tick && !st_r.sw.door && st_r.phase == dltd_pkg::PH_DIM
        && st_r.duty <= {3'h0, st_r.cfg.step}
        |=> st_r.phase == dltd_pkg::PH_OFF && duty_o == 7'h00)
        else $error("dimming did not end off");
endmodule

/* File: tb/dltd_lamp_model.sv */
`timescale 1ns/1ps
module dltd_lamp_model #(
    parameter int unsigned HOLD = 4000
) (
    input  wire logic       clk_sys_in,
    input  wire logic       pwm_in,
    input  wire logic [6:0] load_in,
    output logic [6:0]      current_out
);
    int unsigned hold_r = 0;

    // Filament current held over one PWM frame
    always_ff @(posedge clk_sys_in)
    begin
        if (pwm_in)
            hold_r <= HOLD;
        else if (hold_r != 0)
            hold_r <= hold_r - 1;
    end

    // Plain lamp load, nothing switched behind it
    assign current_out = (hold_r != 0) ? load_in : 7'h00;
endmodule

/* File: tb/dltd_dimmer_tb.sv */
`timescale 1ns/1ps
module dltd_dimmer_tb;
    localparam int unsigned LC = 10;
    localparam logic [31:0] RV [10] = '{32'h1, 32'h1, 32'h50, 32'h14,
        32'h0, 32'h64, 32'h0, 32'hA, 32'h0, 32'h0};
    logic        clk_sys_in    = 1'b0;
    logic        rst_b_in      = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b0;
    logic        door_open_in  = 1'b0;
    logic        ignition_in   = 1'b1;
    logic [6:0]  lamp_current_in;
    logic        lamp_pwm_out;
    logic        irq_out;
    logic [6:0]  load          = 7'h1E;
    logic [31:0] d;
    logic [1:0]  r;
    int          n_fail        = 0;
    int          n_tests       = 0;
    int          k;
    int          t0;
    int          cyc           = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) cyc++;

    dltd_dimmer #(.LOOP_CYCLES(LC)) dltd_dimmer_i (
        .clk_sys_in, .rst_b_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .door_open_in,
        .ignition_in, .lamp_current_in, .lamp_pwm_out, .irq_out);

    dltd_lamp_model dltd_lamp_model_i (
        .clk_sys_in, .pwm_in(lamp_pwm_out), .load_in(load),
        .current_out(lamp_current_in));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_in);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge clk_sys_in); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge clk_sys_in); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_in);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk_sys_in); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys_in); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic chk(input string s, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic cst(input dltd_pkg::dltd_phase_t p, input logic [6:0] u);
        rd(dltd_pkg::ADDR_STATE);
        chk("phase", d[9:7], p);
        chk("duty", d[6:0], u);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #1250000;
        n_fail++;
        print_verdict();
    end

    initial
    begin
        tick(3);
        rst_b_in <= 1'b1;
        // Reset values; open-circuit limit is never written
        for (k = 0; k < 10; k++)
        begin
            rd(8'(k * 4));
            chk("reset value", d, RV[k]);
        end
        rd(8'h30);
        chk("unmapped rresp", r, dltd_pkg::RESP_SLVERR);
        chk("unmapped rdata", d, 32'h0);
        wr(8'h30, 32'h5);
        chk("unmapped bresp", r, dltd_pkg::RESP_SLVERR);
        wr(dltd_pkg::ADDR_STATE, 32'hFFF);
        chk("state bresp", r, dltd_pkg::RESP_OKAY);
        wr(dltd_pkg::ADDR_LEVEL, 32'h32);
        wr(dltd_pkg::ADDR_STEP, 32'hA);
        wr(dltd_pkg::ADDR_WAIT, 32'h1);
        rd(dltd_pkg::ADDR_LEVEL);
        chk("level", d, 32'h32);
        // Full sequence: open, close, wait, dim, off
        door_open_in <= 1'b1;
        tick(10);
        cst(dltd_pkg::PH_FULL, 7'h64);
        door_open_in <= 1'b0;
        t0 = cyc;
        tick(10);
        cst(dltd_pkg::PH_WAIT, 7'h32);
        tick(400);
        cst(dltd_pkg::PH_WAIT, 7'h32);
        do rd(dltd_pkg::ADDR_STATE); while (d[9:7] === dltd_pkg::PH_WAIT);
        chk("wait time", (cyc - t0 >= 495) && (cyc - t0 <= 530), 1);
        k = 50;
        while (d[9:7] === dltd_pkg::PH_DIM)
        begin
            if (d[6:0] !== 7'(k))
            begin
                chk("dim step", d[6:0], k - 10);
                k = k - 10;
            end
            rd(dltd_pkg::ADDR_STATE);
        end
        chk("end phase", d[9:7], dltd_pkg::PH_OFF);
        chk("end duty", d[6:0], 32'h0);
        rd(dltd_pkg::ADDR_STATUS);
        chk("dim done", d, 32'h8);
        chk("irq masked", irq_out, 1'b0);
        wr(dltd_pkg::ADDR_MASK, 32'h8);
        tick(3);
        chk("irq raised", irq_out, 1'b1);
        wr(dltd_pkg::ADDR_STATUS, 32'h8);
        tick(3);
        chk("irq cleared", irq_out, 1'b0);
        // Reopen during wait restores full output
        door_open_in <= 1'b1;
        tick(10);
        door_open_in <= 1'b0;
        tick(100);
        cst(dltd_pkg::PH_WAIT, 7'h32);
        door_open_in <= 1'b1;
        tick(10);
        cst(dltd_pkg::PH_FULL, 7'h64);
        // Dimming disabled: lamp out at close
        wr(dltd_pkg::ADDR_CTRL, 32'h0);
        door_open_in <= 1'b0;
        tick(10);
        cst(dltd_pkg::PH_OFF, 7'h00);
        wr(dltd_pkg::ADDR_CTRL, 32'h1);
        // Overcurrent shut-off and release
        door_open_in <= 1'b1;
        load <= 7'h32;
        wr(dltd_pkg::ADDR_HI_LIM, 32'h14);
        tick(40);
        rd(dltd_pkg::ADDR_STATUS);
        chk("hi fault", d[1], 1'b1);
        rd(dltd_pkg::ADDR_STATE);
        chk("shut duty", d[6:0], 32'h0);
        chk("shut flag", d[10], 1'b1);
        tick(100);
        chk("lamp off", lamp_pwm_out, 1'b0);
        wr(dltd_pkg::ADDR_HI_LIM, 32'h64);
        wr(dltd_pkg::ADDR_STATUS, 32'h2);
        tick(100);
        chk("lamp on", lamp_pwm_out, 1'b1);
        // Low current fault
        wr(dltd_pkg::ADDR_LO_LIM, 32'h3C);
        tick(40);
        rd(dltd_pkg::ADDR_STATUS);
        chk("lo fault", d[0], 1'b1);
        wr(dltd_pkg::ADDR_LO_LIM, 32'h0);
        wr(dltd_pkg::ADDR_STATUS, 32'h1);
        tick(40);
        rd(dltd_pkg::ADDR_STATUS);
        chk("lo clear", d[0], 1'b0);
        // Key-off timeout with the door left open
        wr(dltd_pkg::ADDR_KEYOFF, 32'h1);
        ignition_in <= 1'b0;
        tick(29500);
        cst(dltd_pkg::PH_FULL, 7'h64);
        tick(1000);
        cst(dltd_pkg::PH_KEYOUT, 7'h00);
        rd(dltd_pkg::ADDR_STATUS);
        chk("keyoff flag", d[2], 1'b1);
        print_verdict();
    end
endmodule
